// >>> hdl/sew_write_path.sv
// spi eeprom write path: opcode decode, page buffer, protected self-timed programming
`timescale 1ns/1ps
`default_nettype none
module sew_write_path #(
	parameter int WRITE_CYCLES = sew_pkg::WRITE_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        spi_clk,
	input  wire logic        chip_select_n,
	input  wire logic        spi_mosi,
	input  wire logic        protect_level_bit0,
	input  wire logic        protect_level_bit1,
	output var  logic        busy,
	output var  logic        write_enabled,
	output var  logic [7:0]  status,
	output var  logic        mem_we,
	output var  logic [15:0] mem_addr,
	output var  logic [7:0]  mem_data,
	output var  logic        status_read_cmd,
	output var  logic        write_dropped
);
	localparam int PB = sew_pkg::PAGE_BYTES;
	localparam int CW = $clog2(WRITE_CYCLES + 1);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0]              sck_s;   // sck sync pair plus history
		logic [2:0]              cs_s;
		logic [1:0]              mosi_s;
		logic [1:0]              bp0_s;
		logic [1:0]              bp1_s;
		sew_pkg::sew_state_t     st;
		logic [7:0]              shreg;
		logic [4:0]              bitcnt;
		logic [15:0]             addr;
		logic [15:0]             base;
		logic [PB-1:0]           vld;
		logic                    wel;
		logic [CW-1:0]           tmr;
		logic [6:0]              pidx;
		logic                    busy;
		logic [7:0]              status;
		logic                    mem_we;
		logic [15:0]             mem_addr;
		logic [7:0]              mem_data;
		logic                    srd;
		logic                    drop;
	} sew_reg_t;

	sew_reg_t   r;
	sew_reg_t   next_r;
	logic [7:0] page_buf [PB];        // byte buffer, kept outside the struct
	logic       buf_we;
	logic [6:0] buf_idx;
	logic [7:0] buf_wdata;

	// ------------------------------------------------------------
	// protection test
	// ------------------------------------------------------------
	function automatic logic is_protected(input logic [1:0] lvl, input logic [15:0] a);
		unique case (lvl)
			sew_pkg::LVL_NONE:    is_protected = 1'b0;
			sew_pkg::LVL_QUARTER: is_protected = (a >= sew_pkg::PROT_QUARTER);
			sew_pkg::LVL_HALF:    is_protected = (a >= sew_pkg::PROT_HALF);
			sew_pkg::LVL_ALL:     is_protected = 1'b1;
		endcase
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic       sck_rise;
		logic       cs_fall;
		logic       cs_rise;
		logic [7:0] byte_in;
		logic [7:0] opc;
		logic [15:0] pa;
		sck_rise  = 1'b0;
		cs_fall   = 1'b0;
		cs_rise   = 1'b0;
		byte_in   = 8'h00;
		opc       = 8'h00;
		pa        = 16'h0000;
		next_r    = r;
		buf_we    = 1'b0;
		buf_idx   = r.addr[sew_pkg::PAGE_IDX_W-1:0];
		buf_wdata = 8'h00;
		// only the second stage onward is looked at
		next_r.sck_s  = {r.sck_s[1:0], spi_clk};
		next_r.cs_s   = {r.cs_s[1:0], chip_select_n};
		next_r.mosi_s = {r.mosi_s[0], spi_mosi};
		next_r.bp0_s  = {r.bp0_s[0], protect_level_bit0};
		next_r.bp1_s  = {r.bp1_s[0], protect_level_bit1};
		sck_rise = r.sck_s[1] & ~r.sck_s[2];
		cs_fall  = ~r.cs_s[1] & r.cs_s[2];
		cs_rise  = r.cs_s[1] & ~r.cs_s[2];
		byte_in  = {r.shreg[6:0], r.mosi_s[1]};
		opc      = byte_in & sew_pkg::OPC_MASK;
		next_r.mem_we = 1'b0;
		next_r.srd    = 1'b0;
		next_r.drop   = 1'b0;
		unique case (r.st)
			sew_pkg::SEW_IDLE: begin
				if (cs_fall) begin
					next_r.st     = sew_pkg::SEW_OPCODE;
					next_r.bitcnt = 5'h00;
				end
			end
			sew_pkg::SEW_OPCODE: begin
				if (cs_rise) begin
					next_r.st = sew_pkg::SEW_IDLE;
				end else if (sck_rise) begin
					next_r.shreg  = byte_in;
					next_r.bitcnt = r.bitcnt + 5'h01;
					if (r.bitcnt == 5'h07) begin
						next_r.bitcnt = 5'h00;
						next_r.st     = sew_pkg::SEW_IGNORE;
						if (opc == sew_pkg::OPC_WRITE) begin
							next_r.st = sew_pkg::SEW_ADDR;
						end else if (opc == sew_pkg::OPC_EN_WRITES) begin
							next_r.wel = 1'b1;
						end else if (opc == sew_pkg::OPC_DIS_WRITES) begin
							next_r.wel = 1'b0;
						end else if (opc == sew_pkg::OPC_STATUS_RD) begin
							next_r.srd = 1'b1;
						end
					end
				end
			end
			sew_pkg::SEW_ADDR: begin
				if (cs_rise) begin
					next_r.st   = sew_pkg::SEW_IDLE;
					next_r.drop = 1'b1;
				end else if (sck_rise) begin
					next_r.addr   = {r.addr[14:0], r.mosi_s[1]};
					next_r.bitcnt = r.bitcnt + 5'h01;
					if (r.bitcnt == 5'(sew_pkg::ADDR_W - 1)) begin
						next_r.bitcnt = 5'h00;
						next_r.base   = {r.addr[14:0], r.mosi_s[1]};
						next_r.vld    = '0;
						next_r.st     = sew_pkg::SEW_DATA;
					end
				end
			end
			sew_pkg::SEW_DATA: begin
				if (cs_rise) begin
					// a partial byte at deselect is simply not kept
					if (r.wel && (r.vld != '0)) begin
						next_r.st   = sew_pkg::SEW_PROG;
						next_r.busy = 1'b1;
						next_r.tmr  = '0;
						next_r.pidx = 7'h00;
					end else begin
						next_r.st   = sew_pkg::SEW_IDLE;
						next_r.drop = 1'b1;
					end
				end else if (sck_rise) begin
					next_r.shreg  = byte_in;
					next_r.bitcnt = r.bitcnt + 5'h01;
					if (r.bitcnt == 5'h07) begin
						next_r.bitcnt = 5'h00;
						buf_we        = 1'b1;
						buf_wdata     = byte_in;
						next_r.vld[r.addr[sew_pkg::PAGE_IDX_W-1:0]] = 1'b1;
						next_r.addr   = {r.addr[15:8], r.addr[7:0] + 8'h01};
					end
				end
			end
			sew_pkg::SEW_IGNORE: begin
				if (cs_rise) begin
					next_r.st = sew_pkg::SEW_IDLE;
				end
			end
			sew_pkg::SEW_PROG: begin
				// busy ignores all serial commands except status read
				if (cs_fall) begin
					next_r.bitcnt = 5'h00;
				end else if (sck_rise && ~r.cs_s[1]) begin
					next_r.shreg  = byte_in;
					next_r.bitcnt = r.bitcnt + 5'h01;
					if (r.bitcnt == 5'h07) begin
						next_r.bitcnt = 5'h10;
						if (opc == sew_pkg::OPC_STATUS_RD) begin
							next_r.srd = 1'b1;
						end
					end
				end
				// one buffered byte per clock, protected ones skipped
				pa = {r.base[15:7], r.pidx};
				if (r.vld[r.pidx] && !is_protected({r.bp1_s[1], r.bp0_s[1]}, pa)) begin
					next_r.mem_we   = 1'b1;
					next_r.mem_addr = pa;
					next_r.mem_data = page_buf[r.pidx];
				end
				// the index wraps before the timer ends, so a byte is retired once sent
				next_r.vld[r.pidx] = 1'b0;
				next_r.pidx = r.pidx + 7'h01;
				next_r.tmr  = r.tmr + CW'(1);
				if (r.tmr >= CW'(WRITE_CYCLES - 1)) begin
					next_r.busy = 1'b0;
					next_r.wel  = 1'b0;
					next_r.st   = r.cs_s[1] ? sew_pkg::SEW_IDLE : sew_pkg::SEW_IGNORE;
				end
			end
			default: begin
				next_r.st = sew_pkg::SEW_IDLE;
			end
		endcase
		next_r.status = 8'h00;
		next_r.status[sew_pkg::STAT_BUSY_BIT] = next_r.busy;
		next_r.status[sew_pkg::STAT_WEN_BIT]  = next_r.wel;
		next_r.status[sew_pkg::STAT_BP0_BIT]  = next_r.bp0_s[1];
		next_r.status[sew_pkg::STAT_BP1_BIT]  = next_r.bp1_s[1];
		if (next_r.busy) begin
			next_r.status = 8'hff;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			r       <= '0;
			r.sck_s <= 3'h0;
			r.cs_s  <= 3'h7;
			r.st    <= sew_pkg::SEW_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// page buffer write port
	always_ff @(posedge core_clk) begin
		if (buf_we) begin
			page_buf[buf_idx] <= buf_wdata;
		end
	end

	assign busy            = r.busy;
	assign write_enabled   = r.wel;
	assign status          = r.status;
	assign mem_we          = r.mem_we;
	assign mem_addr        = r.mem_addr;
	assign mem_data        = r.mem_data;
	assign status_read_cmd = r.srd;
	assign write_dropped   = r.drop;
endmodule
`default_nettype wire

// >>> shared/sew_pkg.sv
// constants and types for the serial eeprom write path
package sew_pkg;
	localparam int          OPCODE_W       = 8;
	localparam int          ADDR_W         = 16;
	localparam int          DATA_W         = 8;
	localparam int          PAGE_BYTES     = 128;
	localparam int          PAGE_IDX_W     = 7;
	localparam int          LOW_ADDR_W     = 8;
	// opcode patterns with bit 3 masked out
	localparam logic [7:0]  OPC_MASK       = 8'hf7;
	localparam logic [7:0]  OPC_WRITE      = 8'h02;
	localparam logic [7:0]  OPC_EN_WRITES  = 8'h06;
	localparam logic [7:0]  OPC_DIS_WRITES = 8'h04;
	localparam logic [7:0]  OPC_STATUS_RD  = 8'h05;
	// protect level lower bounds
	localparam logic [15:0] PROT_QUARTER   = 16'hc000;
	localparam logic [15:0] PROT_HALF      = 16'h8000;
	localparam logic [1:0]  LVL_NONE       = 2'h0;
	localparam logic [1:0]  LVL_QUARTER    = 2'h1;
	localparam logic [1:0]  LVL_HALF       = 2'h2;
	localparam logic [1:0]  LVL_ALL        = 2'h3;
	localparam int          STAT_BUSY_BIT  = 0;
	localparam int          STAT_WEN_BIT   = 1;
	localparam int          STAT_BP0_BIT   = 2;
	localparam int          STAT_BP1_BIT   = 3;
	// self-timed cycle length
	localparam int          CLK_MHZ        = 125;
	localparam int          WRITE_TIME_US  = 10000;
	localparam int          WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
	typedef enum logic [2:0] {
		SEW_IDLE,
		SEW_OPCODE,
		SEW_ADDR,
		SEW_DATA,
		SEW_IGNORE,
		SEW_PROG
	} sew_state_t;
endpackage

// >>> tb/sew_host_model.sv
// spi host model driving frames into the write path
`timescale 1ns/1ps
`default_nettype none
module sew_host_model (
	input  wire logic core_clk,
	output var  logic spi_clk,
	output var  logic chip_select_n,
	output var  logic spi_mosi
);
	// ----
	// idle: clock parked low, select high
	// ----
	initial begin
		spi_clk = 1'b0;
		chip_select_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// one frame, bytes msb first, hp core clocks per high half bit, hp plus one per low half
	task automatic frame(input logic [7:0] q[$], input int hp);
		@(posedge core_clk) chip_select_n <= 1'b0;
		foreach (q[i]) for (int b = 7; b >= 0; b--) begin
			@(posedge core_clk) spi_mosi <= q[i][b];
			repeat (hp) @(posedge core_clk);
			spi_clk <= 1'b1;
			repeat (hp) @(posedge core_clk);
			spi_clk <= 1'b0;
		end
		repeat (hp) @(posedge core_clk);
		chip_select_n <= 1'b1;
		spi_mosi <= ~spi_mosi; // released line shows no stale value
		repeat (8) @(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// >>> tb/sew_write_path_checker.sv
// port assertions for the write path
`timescale 1ns/1ps
`default_nettype none
module sew_write_path_checker #(parameter int WRITE_CYCLES = 200) (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        chip_select_n,
	input wire logic        protect_level_bit0,
	input wire logic        protect_level_bit1,
	input wire logic        busy,
	input wire logic        write_enabled,
	input wire logic [7:0]  status,
	input wire logic        mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic        write_dropped
);
	localparam logic [16:0] LIM [4] = '{17'h10000, 17'h0c000, 17'h08000, 17'h00000};
	int cnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// busy length counter, a counter because the cycle is far too long to unroll
	always_ff @(posedge core_clk) cnt <= (rst || !busy) ? 0 : cnt + 1;
	chk_busy_status: assert property (busy |-> status == 8'hff && status[0])
		else $error("status not all ones while busy");
	chk_prog_in_cycle: assert property (mem_we |-> busy)
		else $error("array write outside a cycle");
	chk_start_deselect: assert property ($rose(busy) |-> chip_select_n)
		else $error("cycle started while selected");
	chk_busy_length: assert property ($fell(busy) |-> cnt == WRITE_CYCLES)
		else $error("busy length wrong");
	chk_latch_cleared: assert property ($fell(busy) |-> ##[0:1] !write_enabled)
		else $error("latch kept after cycle");
	chk_busy_no_enable: assert property (busy |=> !$rose(write_enabled))
		else $error("latch set while busy");
	chk_protect_range: assert property (
		mem_we |-> {1'b0, mem_addr} < LIM[{protect_level_bit1, protect_level_bit0}])
		else $error("protected address written");
	chk_drop_no_cycle: assert property (write_dropped |=> !busy [*4])
		else $error("dropped write started a cycle");
	cover property ($rose(busy));
	cover property (write_dropped);
	cover property (mem_we && mem_addr[6:0] == 7'h7f);
endmodule
bind sew_write_path sew_write_path_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
	.core_clk(core_clk), .rst(rst), .chip_select_n(chip_select_n),
	.protect_level_bit0(protect_level_bit0), .protect_level_bit1(protect_level_bit1),
	.busy(busy), .write_enabled(write_enabled), .status(status), .mem_we(mem_we),
	.mem_addr(mem_addr), .write_dropped(write_dropped));
`default_nettype wire

// >>> tb/sew_write_path_tb_top.sv
// self-checking bench for the write path
`timescale 1ns/1ps
`default_nettype none
module sew_write_path_tb_top;
	localparam logic [16:0] LIM [4] = '{17'h10000, 17'h0c000, 17'h08000, 17'h00000};
	logic        core_clk = 0, rst = 1, protect_level_bit0 = 0, protect_level_bit1 = 0;
	logic        spi_clk, chip_select_n, spi_mosi;
	logic        busy, write_enabled, mem_we, status_read_cmd, write_dropped;
	logic [7:0]  status, mem_data;
	logic [15:0] mem_addr;
	logic [23:0] got[$], exp[$];
	int          n_fail = 0, checked = 0, seed = 5137, nsr = 0, ndrop = 0;
	always #4 core_clk = ~core_clk;
	sew_host_model host (.core_clk(core_clk), .spi_clk(spi_clk),
		.chip_select_n(chip_select_n), .spi_mosi(spi_mosi));
	sew_write_path #(.WRITE_CYCLES(200)) dut (.core_clk(core_clk), .rst(rst),
		.spi_clk(spi_clk), .chip_select_n(chip_select_n), .spi_mosi(spi_mosi),
		.protect_level_bit0(protect_level_bit0), .protect_level_bit1(protect_level_bit1),
		.busy(busy), .write_enabled(write_enabled), .status(status), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_data(mem_data), .status_read_cmd(status_read_cmd),
		.write_dropped(write_dropped));
	// ----
	// monitor: array writes and pulse counts
	// ----
	always @(posedge core_clk) begin
		if (mem_we) got.push_back({mem_addr, mem_data});
		nsr += status_read_cmd;
		ndrop += write_dropped;
	end
	task automatic cmp(string nm, logic [23:0] e, logic [23:0] g);
		checked++;
		if (e !== g) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_test;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// bounded wait, a hang shows up as a mismatch
	task automatic wait_busy(logic v);
		for (int k = 0; k < 400 && busy !== v; k++) @(posedge core_clk);
		cmp("busy", v, busy);
	endtask
	// enable, page write, optional commands while busy, then compare the page
	task automatic wr(logic [1:0] lvl, logic [15:0] base, int n, logic [7:0] opc, bit bz);
		logic [7:0] q[$];
		logic [7:0] pg[128];
		logic       hit[128];
		protect_level_bit1 <= lvl[1];
		protect_level_bit0 <= lvl[0];
		hit = '{default: 0};
		got.delete();
		exp.delete();
		host.frame({8'h0e}, 3);
		cmp("latch", 1, write_enabled);
		cmp("status idle", {4'h0, lvl, 2'b10}, status);
		q = {opc, base[15:8], base[7:0]};
		for (int i = 0; i < n; i++) begin
			q.push_back(8'($random(seed)));
			pg[base[6:0] + i[6:0]] = q[i + 3];
			hit[base[6:0] + i[6:0]] = 1;
		end
		host.frame(q, 3 + ($random(seed) & 3));
		wait_busy(1);
		if (bz) begin
			host.frame({8'h06}, 3);
			host.frame({8'h05}, 3);
			cmp("status", 8'hff, status);
			cmp("status reads", 1, nsr);
		end
		wait_busy(0);
		cmp("latch", 0, write_enabled);
		for (int x = 0; x < 128; x++)
			if (hit[x] && {1'b0, base} < LIM[lvl]) exp.push_back({base[15:7], x[6:0], pg[x]});
		cmp("count", exp.size(), got.size());
		foreach (exp[i]) cmp("write", exp[i], got[i]);
	endtask
	initial begin
		repeat (60000) @(posedge core_clk);
		n_fail++;
		stop_test;
	end
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		cmp("reset", 0, {busy, write_enabled, status, mem_we, write_dropped});
		wr(2'h0, 16'h1234, 1, 8'h02, 1);
		host.frame({8'h06}, 3);
		cmp("latch", 1, write_enabled);
		host.frame({8'h0c}, 3);
		cmp("latch", 0, write_enabled);
		host.frame({8'h02, 8'h00, 8'h10, 8'h55}, 4);
		cmp("dropped", 1, ndrop);
		cmp("busy", 0, busy);
		for (int l = 0; l < 4; l++) begin
			wr(l[1:0], 16'h7ff0, 1 + l, 8'h0a, 0);
			wr(l[1:0], 16'h8000 | 15'($random(seed)), 2, 8'h02, 0);
			wr(l[1:0], 16'hc001, 3, 8'h02, 0);
		end
		wr(2'h1, 16'hbf85, 130, 8'h0a, 0);
		stop_test;
	end
endmodule
`default_nettype wire
